// ### rtl/scd_pkg.sv
// Package with register map, field positions and divide ratios of the clock divider.
package scd_pkg;
  // Register byte offsets on the APB side.
  localparam logic [7:0] SCD_CTRL_OFS = 8'h00;
  localparam logic [7:0] SCD_STATUS_OFS = 8'h04;
  // Control register field positions.
  localparam int SCD_CTRL_FUNC_BIT = 0;
  localparam int SCD_CTRL_DSEL_BIT = 1;
  localparam int SCD_CTRL_ENN_BIT = 2;
  localparam int SCD_CTRL_CLR_BIT = 3;
  // Status register field positions.
  localparam int SCD_STAT_FAST_BIT = 0;
  localparam int SCD_STAT_SLOW_BIT = 1;
  localparam int SCD_STAT_RUN_BIT = 2;
  localparam int SCD_STAT_CLK_BIT = 3;
  // Control reset value: selects low, enabled, divider held clear.
  localparam logic [3:0] SCD_CTRL_RESET = 4'h8;
  // Divide ratios expressed in input half periods per output half period.
  localparam logic [2:0] SCD_HALF_DIV1 = 3'h1;
  localparam logic [2:0] SCD_HALF_DIV2 = 3'h2;
  localparam logic [2:0] SCD_HALF_DIV3 = 3'h3;
  localparam logic [2:0] SCD_HALF_DIV4 = 3'h4;
  localparam logic [2:0] SCD_HALF_DIV6 = 3'h6;
endpackage

// ### rtl/scd_divider.sv
// Selectable clock divider with APB control, producing a fast and a slow output pair.
// Contract
// R1: Function select low: fast pair divides input by 2, slow pair by 4 or 6.
// R2: Function select high: fast pair divides by 1, slow pair by 2 or 3.
// R3: Divisor select low picks smaller slow divisor, high picks larger one.
// R4: All divider stages advance on the same input edges so common edges align.
// R5: Active-low enable caught on falling input edge; disabled means outputs hold.
// R6: Enable changes only while the gated internal clock is low; no runt pulses.
// R7: Divider clear high resets all outputs and stages, whatever clock or enable do.
// R8: Controlling logic must pulse divider clear after start-up to align dividers.
// R9: After clear release outputs start low; first enabled rising edge starts sequence.
//
// Chosen here: register access over APB and the register offsets.
module scd_divider
  import scd_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic clk_in,
  output logic [1:0] fast_output_pair,
  output logic [1:0] slow_output_pair
);
  logic [3:0] ctrl;
  logic [3:0] next_ctrl;
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;
  logic clk_s1;
  logic clk_s2;
  logic clk_s3;
  logic run;
  logic next_run;
  logic [2:0] fast_cnt;
  logic [2:0] slow_cnt;
  logic [2:0] next_fast_cnt;
  logic [2:0] next_slow_cnt;
  logic [1:0] next_fast;
  logic [1:0] next_slow;
  logic [1:0] mode_prev;
  logic rise_ev;
  logic fall_ev;
  logic step;
  logic mode_change;
  logic primed;
  logic next_primed;
  logic [2:0] fast_n;
  logic [2:0] slow_n;
  logic function_select;
  logic divisor_select;
  logic enable_n;
  logic divider_clear;

  assign function_select = ctrl[SCD_CTRL_FUNC_BIT];
  assign divisor_select = ctrl[SCD_CTRL_DSEL_BIT];
  assign enable_n = ctrl[SCD_CTRL_ENN_BIT];
  assign divider_clear = ctrl[SCD_CTRL_CLR_BIT];

  // APB slave: the access phase lasts two cycles, pready is a one-cycle registered pulse.
  always_comb
  begin
    next_ctrl = ctrl;
    next_pready = psel && penable && !pready;
    next_prdata = 32'h0000_0000;
    next_pslverr = 1'b0;
    if (psel && penable && pready && pwrite && paddr == SCD_CTRL_OFS)
    begin
      next_ctrl = pwdata[3:0];
    end
    if (next_pready)
    begin
      if (paddr == SCD_CTRL_OFS)
      begin
        next_prdata = {28'h0000000, ctrl};
      end
      else if (paddr == SCD_STATUS_OFS)
      begin
        next_prdata = {28'h0000000, clk_s2, run, slow_output_pair[0], fast_output_pair[0]};
      end
      else
      begin
        next_pslverr = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl <= SCD_CTRL_RESET;
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else
    begin
      ctrl <= next_ctrl;
      pready <= next_pready;
      prdata <= next_prdata;
      pslverr <= next_pslverr;
    end
  end

  // The input clock pin is asynchronous to pclk, so it is synchronised before edge detection.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      clk_s1 <= 1'b0;
      clk_s2 <= 1'b0;
      clk_s3 <= 1'b0;
    end
    else
    begin
      clk_s1 <= clk_in;
      clk_s2 <= clk_s1;
      clk_s3 <= clk_s2;
    end
  end

  assign rise_ev = clk_s2 && !clk_s3;
  assign fall_ev = !clk_s2 && clk_s3;
  // Both edges count as steps while the enable flop is set, but a falling edge counts only
  // once a rising edge has restarted the dividers. Otherwise a clear or mode change released
  // while the input is high would begin the sequence on the wrong edge.
  assign step = run && (rise_ev || (fall_ev && primed)); // R4 R9
  assign mode_change = mode_prev != {divisor_select, function_select};
  assign fast_n = function_select ? SCD_HALF_DIV1 : SCD_HALF_DIV2; // R1 R2
  assign slow_n = function_select ? (divisor_select ? SCD_HALF_DIV3 : SCD_HALF_DIV2)
                                  : (divisor_select ? SCD_HALF_DIV6 : SCD_HALF_DIV4); // R3

  // The enable flop loads only on a falling input edge, when the gated clock is already low.
  always_comb
  begin
    next_run = run;
    if (fall_ev)
    begin
      next_run = !enable_n; // R5 R6
    end
  end

  // Dividers toggle when their half-period counter is zero, so the first step is a rising
  // edge after clear and all pairs change together on it; a mode change restarts both.
  always_comb
  begin
    next_fast_cnt = fast_cnt;
    next_slow_cnt = slow_cnt;
    next_fast = fast_output_pair;
    next_slow = slow_output_pair;
    next_primed = primed;
    if (divider_clear)
    begin
      next_fast_cnt = 3'h0; // R7
      next_slow_cnt = 3'h0;
      next_fast = 2'b00;
      next_slow = 2'b00; // R9
      next_primed = 1'b0;
    end
    else if (mode_change)
    begin
      next_fast_cnt = 3'h0;
      next_slow_cnt = 3'h0;
      next_primed = 1'b0;
    end
    else if (step)
    begin
      next_primed = primed || rise_ev; // R9
      if (fast_cnt == 3'h0)
      begin
        next_fast = ~fast_output_pair;
      end
      if (slow_cnt == 3'h0)
      begin
        next_slow = ~slow_output_pair;
      end
      next_fast_cnt = (fast_cnt + 3'h1 >= fast_n) ? 3'h0 : fast_cnt + 3'h1;
      next_slow_cnt = (slow_cnt + 3'h1 >= slow_n) ? 3'h0 : slow_cnt + 3'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      run <= 1'b0;
      fast_cnt <= 3'h0;
      slow_cnt <= 3'h0;
      fast_output_pair <= 2'b00;
      slow_output_pair <= 2'b00;
      mode_prev <= 2'b00;
      primed <= 1'b0;
    end
    else
    begin
      run <= next_run;
      fast_cnt <= next_fast_cnt;
      slow_cnt <= next_slow_cnt;
      fast_output_pair <= next_fast;
      slow_output_pair <= next_slow;
      mode_prev <= {divisor_select, function_select};
      primed <= next_primed;
    end
  end

  // Checks of the divider behaviour.
  sequence s_fast_step;
    step && !divider_clear && !mode_change && fast_cnt == 3'h0;
  endsequence

  sequence s_slow_step;
    step && !divider_clear && !mode_change && slow_cnt == 3'h0;
  endsequence

  sequence s_restart_step;
    step && !primed && !divider_clear && !mode_change;
  endsequence

  AST_DIV2_FAST: assert property (@(posedge pclk) disable iff (!presetn) // R1
    s_fast_step ##0 !function_select |-> rise_ev ##1 fast_output_pair != $past(fast_output_pair))
    else $error("Divide by two fast pair did not toggle on a rising step.");

  AST_DIV1_FAST: assert property (@(posedge pclk) disable iff (!presetn) // R2
    (step && function_select && !divider_clear && !mode_change) |=> $changed(fast_output_pair))
    else $error("Divide by one fast pair missed an input edge.");

  AST_SLOW_RATIO: assert property (@(posedge pclk) disable iff (!presetn) // R3
    (step && !divider_clear && !mode_change && slow_cnt == slow_n - 3'h1) |=> slow_cnt == 3'h0)
    else $error("Slow divider counter did not wrap at the selected ratio.");

  AST_ALIGN: assert property (@(posedge pclk) disable iff (!presetn) // R4
    s_slow_step |=> $changed(fast_output_pair) && fast_output_pair[0] == fast_output_pair[1])
    else $error("Slow pair edge not matched by a fast pair edge.");

  AST_HOLD: assert property (@(posedge pclk) disable iff (!presetn) // R5
    (!run && !divider_clear) |=> $stable(fast_output_pair) && $stable(slow_output_pair))
    else $error("Outputs moved while the dividers were disabled.");

  AST_NO_RUNT: assert property (@(posedge pclk) disable iff (!presetn) // R6
    $changed(run) |-> !clk_s3 && $past(fall_ev))
    else $error("Enable changed outside a low phase of the input clock.");

  AST_CLEAR: assert property (@(posedge pclk) disable iff (!presetn) // R7
    divider_clear |=> fast_output_pair == 2'b00 && slow_output_pair == 2'b00
      && fast_cnt == 3'h0 && slow_cnt == 3'h0)
    else $error("Divider clear did not reset outputs and stages.");

  AST_START_LOW: assert property (@(posedge pclk) disable iff (!presetn) // R9
    $fell(divider_clear) |-> fast_output_pair == 2'b00 && slow_output_pair == 2'b00
      && fast_cnt == 3'h0 && slow_cnt == 3'h0 && !primed)
    else $error("Outputs did not start low after divider clear was released.");

  AST_FIRST_RISE: assert property (@(posedge pclk) disable iff (!presetn) // R9
    s_restart_step |-> rise_ev ##1 fast_output_pair == ~$past(fast_output_pair)
      && slow_output_pair == ~$past(slow_output_pair))
    else $error("First step after a restart was not a rising edge moving both pairs.");
endmodule

// ### test/scd_clk_source.sv
// Model of the external clock source that drives the divider input.
module scd_clk_source
(
  input wire logic pclk,
  input wire logic run,
  output logic clk_in
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HALF = 4;
  int cnt = 0;
  initial clk_in = 1'b0;
  // Stop only in the low phase, so that no shortened high pulse is ever made.
  always @(posedge pclk)
  begin
    cnt <= (cnt == HALF - 1 || (!run && !clk_in)) ? 0 : cnt + 1;
    if (cnt == HALF - 1 && (run || clk_in))
    begin
      clk_in <= ~clk_in;
    end
  end
endmodule

// ### test/test_selectable_clock_divider.sv
// Self-checking bench for the clock divider with an APB master and clock source.
module test_selectable_clock_divider;
  import scd_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, src_run = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, clk_in, err;
  logic [1:0] fast_output_pair, slow_output_pair;
  int num_errors = 0, checked = 0;
  scd_divider dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .clk_in(clk_in), .fast_output_pair(fast_output_pair),
    .slow_output_pair(slow_output_pair));
  scd_clk_source src (.pclk(pclk), .run(src_run), .clk_in(clk_in));
  // Bus clock at 200 MHz.
  always #2.5 pclk = ~pclk;
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // One APB transfer; the request stands until pready is seen at a rising edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50)
    begin
      num_errors++;
      report_and_stop();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Counts output rises over twelve input periods and checks both bits of each pair agree.
  task automatic measure(input int ef, input int es);
    int nf, ns, bad;
    logic pf, ps;
    nf = 0;
    ns = 0;
    bad = 0;
    pf = fast_output_pair[0];
    ps = slow_output_pair[0];
    repeat (100)
    begin
      @(negedge pclk);
      nf += (fast_output_pair[0] && !pf);
      ns += (slow_output_pair[0] && !ps);
      bad += (fast_output_pair[1] !== fast_output_pair[0]);
      bad += (slow_output_pair[1] !== slow_output_pair[0]);
      pf = fast_output_pair[0];
      ps = slow_output_pair[0];
    end
    @(posedge pclk);
    check("fast rises", nf, ef);
    check("slow rises", ns, es);
    check("pair copies", bad, 0);
  endtask
  int ef[4] = '{6, 12, 6, 12};
  int es[4] = '{3, 6, 2, 4};
  // Main sequence.
  initial
  begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, SCD_CTRL_OFS, 32'h0);
    check("ctrl reset", rd, {28'h0, SCD_CTRL_RESET});
    apb(1'b0, 8'h08, 32'h0);
    check("unmapped err", {rd[30:0], err}, 32'h1);
    apb(1'b1, SCD_STATUS_OFS, 32'h5);
    check("status write err", err, 0);
    src_run <= 1'b1;
    repeat (20) @(posedge pclk);
    check("outputs in clear", {fast_output_pair, slow_output_pair}, 0);
    apb(1'b0, SCD_STATUS_OFS, 32'h0);
    check("run loaded", rd[SCD_STAT_RUN_BIT], 1);
    src_run <= 1'b0;
    for (int m = 0; m < 4; m++)
    begin
      repeat (12) @(posedge pclk);
      apb(1'b1, SCD_CTRL_OFS, 32'h8 | m);
      apb(1'b1, SCD_CTRL_OFS, m);
      check("start low", {fast_output_pair, slow_output_pair}, 0);
      src_run <= 1'b1;
      measure(ef[m], es[m]);
      src_run <= 1'b0;
    end
    apb(1'b1, SCD_CTRL_OFS, 32'h4);
    src_run <= 1'b1;
    repeat (20) @(posedge pclk);
    measure(0, 0);
    apb(1'b1, SCD_CTRL_OFS, 32'hc);
    repeat (3) @(posedge pclk);
    check("clear while held", {fast_output_pair, slow_output_pair}, 0);
    report_and_stop();
  end
  // Watchdog sized well beyond the roughly 660 cycles the tests need.
  initial
  begin
    #50000;
    num_errors++;
    report_and_stop();
  end
endmodule
